// File: rtl/osdc_pkg.sv
// Package for the operating state and debug control block.
// Assumes one system clock domain and an external debugger on plain pins.
package osdc_pkg;

  // Data path widths of the processor seen by the debug logic
  localparam int PC_W   = 14;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int N_BP   = 5;  // One program-counter break plus four memory spaces
  localparam int N_SPC  = 4;  // Memory spaces watched by address breaks
  localparam int TR_W   = 7;  // Widest trace word

  // Operating states, one-hot
  typedef enum logic [3:0] {
    OSDC_ST_RUN   = 4'h1,
    OSDC_ST_HOLD  = 4'h2,
    OSDC_ST_SLEEP = 4'h4,
    OSDC_ST_WAIT  = 4'h8
  } osdc_state_t;

  // State indicator codes, bit 2 down to bit 0
  localparam logic [2:0] IND_RUN        = 3'h0;
  localparam logic [2:0] IND_SLEEP      = 3'h2;
  localparam logic [2:0] IND_WAIT       = 3'h1;
  localparam logic [2:0] IND_HOLD_RUN   = 3'h4;
  localparam logic [2:0] IND_HOLD_SLEEP = 3'h6;
  localparam logic [2:0] IND_HOLD_WAIT  = 3'h5;

  // Debug access spaces
  localparam logic [2:0] SPC_REG  = 3'h0;
  localparam logic [2:0] SPC_IMEM = 3'h1;
  localparam logic [2:0] SPC_DMEM = 3'h2;
  localparam logic [2:0] SPC_DRAM = 3'h3;
  localparam logic [2:0] SPC_DBC  = 3'h7;

  // Word indices inside the debug controller space
  localparam logic [ADDR_W-1:0] DBC_BP_PC    = 16'h0000;
  localparam logic [ADDR_W-1:0] DBC_BP_LAST  = 16'h0004;
  localparam logic [ADDR_W-1:0] DBC_BP_EN    = 16'h0005;
  localparam logic [ADDR_W-1:0] DBC_TR_MODE  = 16'h0006;
  localparam logic [ADDR_W-1:0] DBC_STATUS   = 16'h0007;

  // Trace forms
  localparam logic TR_MODE_1BIT = 1'b0;
  localparam logic TR_MODE_7BIT = 1'b1;

  // Request from the debugger pins
  typedef struct packed {
    logic              req;
    logic              we;
    logic [2:0]        space;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } osdc_dbg_req_t;

  // Whole state of the block
  typedef struct packed {
    osdc_state_t                  state;
    logic                         from_sleep;
    logic                         from_wait;
    logic                         started;
    logic                         brk_pend;
    logic [N_BP-1:0][ADDR_W-1:0]  bp_val;
    logic [N_BP-1:0]              bp_en;
    logic                         tr_mode;
    logic [PC_W-1:0]              prev_pc;
    logic [TR_W-1:0]              trace;
    logic                         trace_vld;
    logic [2:0]                   ind;
    logic                         run;
    logic                         busy;
    osdc_dbg_req_t                mem;
    logic                         dbg_ack;
    logic                         dbg_err;
    logic [DATA_W-1:0]            dbg_rdata;
    logic                         rst_s1;
    logic                         rst_s2;
    logic                         halt_s1;
    logic                         halt_s2;
  } osdc_regs_t;

  localparam osdc_regs_t OSDC_RESET = '{state: OSDC_ST_RUN, default: '0};

endpackage

// File: rtl/osdc_top.sv
// Operating state sequencer and debug controller of the processor.
// Assumes the core reports instruction boundaries and honours the run output.
//
// What this block does
// R1 - Exactly four operating states exist: run, hold, sleep and wait.
// R2 - Run executes the program; hold stops program execution.
// R3 - Sleep and wait both keep program execution stopped.
// R4 - Wait watches selected processing and returns to run itself on completion.
// R5 - Hold lets outside circuits read and write instruction and data memory.
// R6 - Nothing runs until the active-low chip reset pin is released.
// R7 - Halt request pin stops and restarts; hold entered from run, sleep or wait.
// R8 - Indicator shows run 000, sleep 010, wait 001.
// R9 - In hold indicator shows origin: run 100, sleep 110, wait 101.
// R10 - Debugger must enter hold before touching internal resources.
// R11 - In hold, external reads and writes of registers, memories and DRAM.
// R12 - Breaks on PC and four memory spaces; PC trace in 1-bit or 7-bit form.
// R13 - Halt pin synchronised; run is left only at instruction boundaries, sleep, wait and hold react at once.
`timescale 1ns/1ps
module osdc_top (
  input  wire logic                                          CLK_SYS_I,
  input  wire logic                                          SYS_RST_I,
  input  wire logic                                          CHIP_RESET_PIN_N_I,
  input  wire logic                                          HALT_REQUEST_PIN_I,
  input  wire logic                                          INSTR_BOUNDARY_I,
  input  wire logic [osdc_pkg::PC_W-1:0]                     PC_I,
  input  wire logic                                          SLEEP_REQ_I,
  input  wire logic                                          WAKE_I,
  input  wire logic                                          WAIT_REQ_I,
  input  wire logic                                          WAIT_DONE_I,
  input  wire logic [osdc_pkg::N_SPC-1:0]                    ACC_VLD_I,
  input  wire logic [osdc_pkg::N_SPC-1:0][osdc_pkg::ADDR_W-1:0] ACC_ADDR_I,
  input  wire logic                                          DBG_REQ_I,
  input  wire logic                                          DBG_WE_I,
  input  wire logic [2:0]                                    DBG_SPACE_I,
  input  wire logic [osdc_pkg::ADDR_W-1:0]                   DBG_ADDR_I,
  input  wire logic [osdc_pkg::DATA_W-1:0]                   DBG_WDATA_I,
  input  wire logic                                          MEM_ACK_I,
  input  wire logic [osdc_pkg::DATA_W-1:0]                   MEM_RDATA_I,
  output logic      [2:0]                                    STATE_INDICATOR_O,
  output logic                                               CORE_RUN_O,
  output logic                                               DBG_ACK_O,
  output logic                                               DBG_ERR_O,
  output logic      [osdc_pkg::DATA_W-1:0]                   DBG_RDATA_O,
  output logic                                               MEM_REQ_O,
  output logic                                               MEM_WE_O,
  output logic      [2:0]                                    MEM_SPACE_O,
  output logic      [osdc_pkg::ADDR_W-1:0]                   MEM_ADDR_O,
  output logic      [osdc_pkg::DATA_W-1:0]                   MEM_WDATA_O,
  output logic      [osdc_pkg::TR_W-1:0]                     TRACE_O,
  output logic                                               TRACE_VLD_O
);

  osdc_pkg::osdc_regs_t         cur_r;
  osdc_pkg::osdc_regs_t         cur_nxt;
  logic [osdc_pkg::N_BP-1:0]    bp_hit;
  logic                         brk_hit;
  logic [osdc_pkg::PC_W-1:0]    pc_seq;
  logic [2:0]                   bp_idx;

  // Program-counter compare sits in slot zero
  assign bp_hit[0] = (cur_r.bp_val[0] == osdc_pkg::ADDR_W'(PC_I)); // see R12

  // One address comparator per watched memory space
  genvar gi;
  generate
    for (gi = 0; gi < osdc_pkg::N_SPC; gi = gi + 1) begin : g_spc_bp
      assign bp_hit[gi+1] = ACC_VLD_I[gi] && (cur_r.bp_val[gi+1] == ACC_ADDR_I[gi]); // see R12
    end
  endgenerate

  assign brk_hit = |(bp_hit & cur_r.bp_en);
  assign pc_seq  = cur_r.prev_pc + osdc_pkg::PC_W'(1);
  assign bp_idx  = DBG_ADDR_I[2:0];

  // Next-state logic for the whole block
  always_comb begin
    cur_nxt           = cur_r;
    // Two-flop synchronisers; first stage feeds only the second
    cur_nxt.rst_s1    = CHIP_RESET_PIN_N_I;
    cur_nxt.rst_s2    = cur_r.rst_s1;
    cur_nxt.halt_s1   = HALT_REQUEST_PIN_I; // see R13
    cur_nxt.halt_s2   = cur_r.halt_s1;
    cur_nxt.dbg_ack   = 1'b0;
    cur_nxt.dbg_err   = 1'b0;
    cur_nxt.mem.req   = 1'b0;
    cur_nxt.trace_vld = 1'b0;

    if (!cur_r.rst_s2) begin
      // Chip reset pin held low: core parked, break enables cleared (break values and trace mode kept)
      cur_nxt.state      = osdc_pkg::OSDC_ST_RUN; // see R6
      cur_nxt.started    = 1'b0;
      cur_nxt.from_sleep = 1'b0;
      cur_nxt.from_wait  = 1'b0;
      cur_nxt.brk_pend   = 1'b0;
      cur_nxt.bp_en      = '0;
      cur_nxt.busy       = 1'b0;
    end else begin
      cur_nxt.started = 1'b1; // see R6
      // Sleep and wait have no instruction in flight, so they react at once;
      // run only moves on a boundary so no instruction is split
      case (cur_r.state)
        osdc_pkg::OSDC_ST_RUN: begin
          if (cur_r.started && INSTR_BOUNDARY_I) begin // see R13
            cur_nxt.prev_pc   = PC_I;
            cur_nxt.trace_vld = 1'b1; // see R12
            if (cur_r.tr_mode == osdc_pkg::TR_MODE_7BIT) begin
              cur_nxt.trace = PC_I[osdc_pkg::TR_W-1:0];
            end else begin
              cur_nxt.trace = {{(osdc_pkg::TR_W-1){1'b0}}, PC_I != pc_seq}; // Flow break flag
            end
            if (cur_r.halt_s2 || brk_hit) begin
              cur_nxt.state      = osdc_pkg::OSDC_ST_HOLD; // see R7
              cur_nxt.from_sleep = 1'b0;
              cur_nxt.from_wait  = 1'b0;
              cur_nxt.brk_pend   = brk_hit; // see R12
            end else if (WAIT_REQ_I) begin
              cur_nxt.state = osdc_pkg::OSDC_ST_WAIT;
            end else if (SLEEP_REQ_I) begin
              cur_nxt.state = osdc_pkg::OSDC_ST_SLEEP;
            end
          end
        end
        osdc_pkg::OSDC_ST_SLEEP: begin
          if (cur_r.halt_s2) begin
            cur_nxt.state      = osdc_pkg::OSDC_ST_HOLD; // see R7
            cur_nxt.from_sleep = 1'b1;
            cur_nxt.from_wait  = 1'b0;
          end else if (WAKE_I) begin
            cur_nxt.state = osdc_pkg::OSDC_ST_RUN;
          end
        end
        osdc_pkg::OSDC_ST_WAIT: begin
          if (cur_r.halt_s2) begin
            cur_nxt.state      = osdc_pkg::OSDC_ST_HOLD; // see R7
            cur_nxt.from_sleep = 1'b0;
            cur_nxt.from_wait  = 1'b1;
          end else if (WAIT_DONE_I) begin
            cur_nxt.state = osdc_pkg::OSDC_ST_RUN; // see R4
          end
        end
        osdc_pkg::OSDC_ST_HOLD: begin
          // A break stays held until the debugger pulses the halt pin,
          // otherwise a low halt pin would resume straight away
          if (cur_r.halt_s2) begin
            cur_nxt.brk_pend = 1'b0;
          end
          if (!cur_r.halt_s2 && !cur_r.brk_pend) begin
            if (cur_r.from_sleep) begin
              cur_nxt.state = osdc_pkg::OSDC_ST_SLEEP; // see R7
            end else if (cur_r.from_wait) begin
              cur_nxt.state = osdc_pkg::OSDC_ST_WAIT;
            end else begin
              cur_nxt.state = osdc_pkg::OSDC_ST_RUN;
            end
          end
        end
        default: begin
          cur_nxt.state = osdc_pkg::OSDC_ST_RUN; // see R1
        end
      endcase

      // Debug access port, one request in flight at a time
      if (cur_r.busy) begin
        if (MEM_ACK_I) begin
          cur_nxt.busy      = 1'b0;
          cur_nxt.dbg_ack   = 1'b1;
          cur_nxt.dbg_rdata = cur_r.mem.we ? '0 : MEM_RDATA_I;
        end
      end else if (DBG_REQ_I) begin
        cur_nxt.dbg_rdata = '0;
        if (DBG_SPACE_I == osdc_pkg::SPC_DBC) begin
          // Break and trace setup is open in every state
          cur_nxt.dbg_ack = 1'b1;
          if (DBG_ADDR_I <= osdc_pkg::DBC_BP_LAST) begin
            if (DBG_WE_I) begin
              cur_nxt.bp_val[bp_idx] = DBG_WDATA_I; // see R12
            end
            cur_nxt.dbg_rdata = cur_r.bp_val[bp_idx];
          end else if (DBG_ADDR_I == osdc_pkg::DBC_BP_EN) begin
            if (DBG_WE_I) begin
              cur_nxt.bp_en = DBG_WDATA_I[osdc_pkg::N_BP-1:0];
            end
            cur_nxt.dbg_rdata = osdc_pkg::DATA_W'(cur_r.bp_en);
          end else if (DBG_ADDR_I == osdc_pkg::DBC_TR_MODE) begin
            if (DBG_WE_I) begin
              cur_nxt.tr_mode = DBG_WDATA_I[0];
            end
            cur_nxt.dbg_rdata = osdc_pkg::DATA_W'(cur_r.tr_mode);
          end else if (DBG_ADDR_I == osdc_pkg::DBC_STATUS) begin
            cur_nxt.dbg_rdata = {{(osdc_pkg::DATA_W-4){1'b0}}, cur_r.brk_pend, cur_r.ind};
          end else begin
            cur_nxt.dbg_err = 1'b1; // Unmapped word
          end
        end else if (cur_r.state == osdc_pkg::OSDC_ST_HOLD &&
                     DBG_SPACE_I <= osdc_pkg::SPC_DRAM) begin
          // Registers, memories and DRAM reached only while held
          cur_nxt.busy      = 1'b1; // see R5, R11
          cur_nxt.mem.req   = 1'b1;
          cur_nxt.mem.we    = DBG_WE_I;
          cur_nxt.mem.space = DBG_SPACE_I;
          cur_nxt.mem.addr  = DBG_ADDR_I;
          cur_nxt.mem.wdata = DBG_WDATA_I;
        end else begin
          // Outside hold, or to an unmapped space, the result would be undefined, so refuse it
          cur_nxt.dbg_ack = 1'b1; // see R10
          cur_nxt.dbg_err = 1'b1;
        end
      end
    end

    // Indicator follows the state being entered
    case (cur_nxt.state)
      osdc_pkg::OSDC_ST_SLEEP: cur_nxt.ind = osdc_pkg::IND_SLEEP; // see R8
      osdc_pkg::OSDC_ST_WAIT:  cur_nxt.ind = osdc_pkg::IND_WAIT;
      osdc_pkg::OSDC_ST_HOLD: begin
        if (cur_nxt.from_sleep) begin
          cur_nxt.ind = osdc_pkg::IND_HOLD_SLEEP; // see R9
        end else if (cur_nxt.from_wait) begin
          cur_nxt.ind = osdc_pkg::IND_HOLD_WAIT;
        end else begin
          cur_nxt.ind = osdc_pkg::IND_HOLD_RUN;
        end
      end
      default: cur_nxt.ind = osdc_pkg::IND_RUN;
    endcase
    cur_nxt.run = cur_nxt.started && (cur_nxt.state == osdc_pkg::OSDC_ST_RUN); // see R2, R3
  end

  // State register
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cur_r <= osdc_pkg::OSDC_RESET;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // Outputs straight from the state register
  assign STATE_INDICATOR_O = cur_r.ind;
  assign CORE_RUN_O        = cur_r.run;
  assign DBG_ACK_O         = cur_r.dbg_ack;
  assign DBG_ERR_O         = cur_r.dbg_err;
  assign DBG_RDATA_O       = cur_r.dbg_rdata;
  assign MEM_REQ_O         = cur_r.mem.req;
  assign MEM_WE_O          = cur_r.mem.we;
  assign MEM_SPACE_O       = cur_r.mem.space;
  assign MEM_ADDR_O        = cur_r.mem.addr;
  assign MEM_WDATA_O       = cur_r.mem.wdata;
  assign TRACE_O           = cur_r.trace;
  assign TRACE_VLD_O       = cur_r.trace_vld;

endmodule

// File: dv/osdc_mem_model.sv
// Model of the internal resources behind the debug port.
// Assumes forwarded requests come as one-cycle pulses with fields held.
`timescale 1ns/1ps
module osdc_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [2:0]  space_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  output logic             ack_o,
  output logic [15:0]      rdata_o
);
  logic [15:0] mem [16];
  logic [1:0]  cnt;
  logic        busy;
  // Low address bits set the delay, so both prompt and slow answers occur
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o   <= 1'b0;
      busy    <= 1'b0;
      cnt     <= 2'h0;
      rdata_o <= 16'h0000;
    end else begin
      ack_o   <= 1'b0;
      rdata_o <= ~rdata_o; // Idle data toggles so stale values never match
      if (req_i) begin
        busy <= 1'b1;
        cnt  <= addr_i[1:0];
      end else if (busy && cnt != 2'h0) begin
        cnt <= cnt - 2'h1;
      end else if (busy) begin
        busy    <= 1'b0;
        ack_o   <= 1'b1;
        rdata_o <= mem[{space_i[1:0], addr_i[1:0]}];
        if (we_i) begin
          mem[{space_i[1:0], addr_i[1:0]}] <= wdata_i;
        end
      end
    end
  end
endmodule

// File: dv/osdc_props.sv
// Checker of the operating state block, seeing top-level ports only.
// Assumes the bind at the foot attaches it to every top instance.
`timescale 1ns/1ps
module osdc_props (
  input wire logic       CLK_SYS_I,
  input wire logic       SYS_RST_I,
  input wire logic       CHIP_RESET_PIN_N_I,
  input wire logic       HALT_REQUEST_PIN_I,
  input wire logic       INSTR_BOUNDARY_I,
  input wire logic       WAIT_DONE_I,
  input wire logic [2:0] STATE_INDICATOR_O,
  input wire logic       CORE_RUN_O,
  input wire logic       DBG_ACK_O,
  input wire logic       MEM_REQ_O,
  input wire logic       TRACE_VLD_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);
  // Pins are synchronised, so conditions look back over several cycles
  property p_ind_legal;
    STATE_INDICATOR_O inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  endproperty
  a_ind_legal: assert property (p_ind_legal) else $error("bad indicator");
  property p_stop;
    CORE_RUN_O |-> STATE_INDICATOR_O == 3'h0;
  endproperty
  a_stop: assert property (p_stop) else $error("runs outside run");
  property p_wait_done;
    (!HALT_REQUEST_PIN_I && CHIP_RESET_PIN_N_I) [*3] ##0
      (STATE_INDICATOR_O == 3'h1 && WAIT_DONE_I) |=> STATE_INDICATOR_O == 3'h0 && CORE_RUN_O;
  endproperty
  a_wait_done: assert property (p_wait_done) else $error("wait not left");
  property p_hold_origin;
    $rose(STATE_INDICATOR_O[2]) |-> STATE_INDICATOR_O[1:0] == $past(STATE_INDICATOR_O[1:0]);
  endproperty
  a_hold_origin: assert property (p_hold_origin) else $error("hold origin lost");
  property p_resume;
    CHIP_RESET_PIN_N_I [*4] ##0 $fell(STATE_INDICATOR_O[2])
      |-> STATE_INDICATOR_O == {1'b0, $past(STATE_INDICATOR_O[1:0])};
  endproperty
  a_resume: assert property (p_resume) else $error("wrong state after hold");
  property p_start;
    !CHIP_RESET_PIN_N_I [*5] |-> !CORE_RUN_O;
  endproperty
  a_start: assert property (p_start) else $error("runs in chip reset");
  property p_mem_hold;
    MEM_REQ_O |-> $past(STATE_INDICATOR_O[2]);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("access outside hold");
  property p_fwd_ack;
    MEM_REQ_O |=> !MEM_REQ_O ##[0:8] DBG_ACK_O;
  endproperty
  a_fwd_ack: assert property (p_fwd_ack) else $error("forwarded access unanswered");
  property p_trace;
    TRACE_VLD_O |-> $past(INSTR_BOUNDARY_I);
  endproperty
  a_trace: assert property (p_trace) else $error("trace without boundary");
  property p_boundary;
    $fell(CORE_RUN_O) && STATE_INDICATOR_O != 3'h0 |-> $past(INSTR_BOUNDARY_I);
  endproperty
  a_boundary: assert property (p_boundary) else $error("left run mid instruction");
endmodule
bind osdc_top osdc_props chk (.CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I),
  .CHIP_RESET_PIN_N_I(CHIP_RESET_PIN_N_I), .HALT_REQUEST_PIN_I(HALT_REQUEST_PIN_I),
  .INSTR_BOUNDARY_I(INSTR_BOUNDARY_I), .WAIT_DONE_I(WAIT_DONE_I),
  .STATE_INDICATOR_O(STATE_INDICATOR_O), .CORE_RUN_O(CORE_RUN_O), .DBG_ACK_O(DBG_ACK_O),
  .MEM_REQ_O(MEM_REQ_O), .TRACE_VLD_O(TRACE_VLD_O));

// File: dv/osdc_top_tb_top.sv
// Self-checking bench of the operating state and debug block.
// Assumes the resource model answers forwarded debug accesses.
`timescale 1ns/1ps
module osdc_top_tb_top;
  logic clk = 1'b0, rst = 1'b1, chip_n = 1'b0, halt = 1'b0, bnd = 1'b0, jmp = 1'b0;
  logic slp = 1'b0, wake = 1'b0, wreq = 1'b0, wdone = 1'b0, dreq = 1'b0, dwe = 1'b0;
  logic [13:0] pc = 14'h0000;
  logic [3:0] avld = 4'h0;
  logic [3:0][15:0] aaddr = '0;
  logic [2:0] dspc = 3'h0, ind, mspc;
  logic [15:0] daddr = 16'h0000, dwd = 16'h0000, drd, mrd, maddr, mwd, rd;
  logic mack, dack, derr, mreq, mwe, crun, trv, er;
  logic [6:0] tr;
  int n_mismatch = 0, tests_run = 0, cycles = 0;
  osdc_top dut (.CLK_SYS_I(clk), .SYS_RST_I(rst), .CHIP_RESET_PIN_N_I(chip_n),
    .HALT_REQUEST_PIN_I(halt), .INSTR_BOUNDARY_I(bnd), .PC_I(pc), .SLEEP_REQ_I(slp),
    .WAKE_I(wake), .WAIT_REQ_I(wreq), .WAIT_DONE_I(wdone), .ACC_VLD_I(avld),
    .ACC_ADDR_I(aaddr), .DBG_REQ_I(dreq), .DBG_WE_I(dwe), .DBG_SPACE_I(dspc),
    .DBG_ADDR_I(daddr), .DBG_WDATA_I(dwd), .MEM_ACK_I(mack), .MEM_RDATA_I(mrd),
    .STATE_INDICATOR_O(ind), .CORE_RUN_O(crun), .DBG_ACK_O(dack), .DBG_ERR_O(derr),
    .DBG_RDATA_O(drd), .MEM_REQ_O(mreq), .MEM_WE_O(mwe), .MEM_SPACE_O(mspc),
    .MEM_ADDR_O(maddr), .MEM_WDATA_O(mwd), .TRACE_O(tr), .TRACE_VLD_O(trv));
  osdc_mem_model mem (.clk_i(clk), .rst_i(rst), .req_i(mreq), .we_i(mwe), .space_i(mspc),
    .addr_i(maddr), .wdata_i(mwd), .ack_o(mack), .rdata_o(mrd));
  // Clock, and a core that retires one instruction per cycle once started
  always #4 clk = ~clk;
  always @(posedge clk) if (bnd) pc <= pc + 14'h1 + {13'h0, jmp};
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test;
    end
  end
  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (e !== g) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bounded wait for an indicator code; a stuck state shows as a mismatch
  task wait_ind(input logic [2:0] e, input string nm);
    int i;
    i = 0;
    #1; // Never look at the indicator in the step of the edge that moves it
    while (ind !== e && i < 40) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk(nm, 16'(e), 16'(ind));
  endtask
  // One debug word: request pulse, then a bounded wait for the answer
  task dbg(input logic we, input logic [2:0] sp, input logic [15:0] a, input logic [15:0] w);
    int i;
    @(posedge clk);
    dreq  <= 1'b1;
    dwe   <= we;
    dspc  <= sp;
    daddr <= a;
    dwd   <= w;
    @(posedge clk);
    dreq <= 1'b0;
    #1;
    i = 0;
    while (dack !== 1'b1 && i < 40) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk("dbg_ack", 16'h1, 16'(dack));
    rd = drd;
    er = derr;
  endtask
  task pulse_halt;
    @(posedge clk); halt <= 1'b1;
    repeat (4) @(posedge clk);
    halt <= 1'b0;
    wait_ind(3'h0, "resume");
  endtask
  task t_start;
    repeat (10) @(posedge clk);
    #1;
    chk("pre_run", 16'h0, 16'(crun));
    @(posedge clk); chip_n <= 1'b1; bnd <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk("started", 16'h1, 16'(crun));
  endtask
  task t_hold_run;
    @(posedge clk); halt <= 1'b1;
    wait_ind(3'h4, "hold_run");
    chk("hold_stop", 16'h0, 16'(crun));
    @(posedge clk); halt <= 1'b0;
    wait_ind(3'h0, "run_back");
    chk("run_go", 16'h1, 16'(crun));
  endtask
  // Sleep when w is 0, wait when w is 1; hold from there returns there
  task t_park(input logic w);
    logic [2:0] code;
    code = w ? 3'h1 : 3'h2;
    @(posedge clk);
    wreq <= w;
    slp  <= !w;
    @(posedge clk);
    wreq <= 1'b0;
    slp  <= 1'b0;
    wait_ind(code, "park");
    chk("park_stop", 16'h0, 16'(crun));
    @(posedge clk); halt <= 1'b1;
    wait_ind(code | 3'h4, "hold_park");
    @(posedge clk); halt <= 1'b0;
    wait_ind(code, "park_back");
    repeat (5) @(posedge clk);
    #1;
    chk("still_parked", 16'(code), 16'(ind));
    @(posedge clk);
    wdone <= w;
    wake  <= !w;
    @(posedge clk);
    wdone <= 1'b0;
    wake  <= 1'b0;
    wait_ind(3'h0, "unpark");
  endtask
  task t_debug;
    dbg(1'b0, 3'h2, 16'h0001, 16'h0000);
    chk("run_refused", 16'h1, 16'(er));
    @(posedge clk); halt <= 1'b1;
    wait_ind(3'h4, "dbg_hold");
    for (int s = 0; s < 4; s++) begin
      dbg(1'b1, 3'(s), 16'(s), 16'h5a00 + 16'(s));
      chk("wr_data", 16'h0, rd);
      dbg(1'b0, 3'(s), 16'(s), 16'h0000);
      chk("rd_data", 16'h5a00 + 16'(s), rd);
      chk("rd_err", 16'h0, 16'(er));
    end
    dbg(1'b0, 3'h5, 16'h0000, 16'h0000);
    chk("bad_space", 16'h1, 16'(er));
    // Unmapped word of the debug controller space is refused too
    dbg(1'b0, 3'h7, 16'h0008, 16'h0000);
    chk("bad_word", 16'h1, 16'(er));
    chk("hold_trace", 16'h0, 16'(trv));
    @(posedge clk); halt <= 1'b0;
    wait_ind(3'h0, "dbg_run");
  endtask
  // Program-counter break, then one address break in each memory space
  task t_break;
    dbg(1'b1, 3'h7, 16'h0000, {2'h0, pc + 14'h001e});
    dbg(1'b1, 3'h7, 16'h0005, 16'h0001);
    wait_ind(3'h4, "pc_break");
    dbg(1'b0, 3'h7, 16'h0007, 16'h0000);
    chk("break_status", 16'h000c, rd);
    for (int s = 0; s < 4; s++) begin
      dbg(1'b1, 3'h7, 16'(s + 1), 16'h0100 + 16'(s));
      dbg(1'b1, 3'h7, 16'h0005, 16'(1 << (s + 1)));
      pulse_halt;
      @(posedge clk);
      avld[s]  <= 1'b1;
      aaddr[s] <= 16'h0100 + 16'(s);
      wait_ind(3'h4, "acc_break");
      @(posedge clk);
      avld <= 4'h0;
    end
    dbg(1'b1, 3'h7, 16'h0005, 16'h0000);
    pulse_halt;
  endtask
  task t_trace;
    dbg(1'b1, 3'h7, 16'h0006, 16'h0001);
    repeat (3) begin
      @(posedge clk);
      #1;
      chk("trace7", 16'(pc - 14'h1) & 16'h007f, 16'(tr));
      chk("trace_vld", 16'h1, 16'(trv));
    end
    dbg(1'b1, 3'h7, 16'h0006, 16'h0000);
    repeat (2) @(posedge clk);
    #1;
    chk("trace1_seq", 16'h0, 16'(tr));
    @(posedge clk); jmp <= 1'b1;
    @(posedge clk); jmp <= 1'b0;
    @(posedge clk);
    #1;
    chk("trace1_jump", 16'h1, 16'(tr));
  endtask
  // Main sequence: two cycles of reset, then the scenarios in turn
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_start;
    t_hold_run;
    t_park(1'b0);
    t_park(1'b1);
    t_debug;
    t_break;
    t_trace;
    stop_test;
  end
endmodule
